// file: hw/tcsu_pkg.sv
package tcsu_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CONTROL_A = 8'h00;
    localparam logic [7:0] OFF_CTRLBCLR = 8'h04;
    localparam logic [7:0] OFF_CONTROL_B_SET = 8'h08;
    localparam logic [7:0] OFF_EVENT_CONTROL_REG = 8'h0C;
    localparam logic [7:0] OFF_WAVE = 8'h10;
    localparam logic [7:0] OFF_DRIVE_CONTROL_REG = 8'h14;
    localparam logic [7:0] OFF_DEBUG_CONTROL_REG = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [7:0] OFF_COUNT = 8'h20;
    localparam logic [7:0] OFF_PER = 8'h24;
    localparam logic [7:0] OFF_CC0 = 8'h28;
    localparam logic [7:0] OFF_CC1 = 8'h2C;
    // control_a fields
    localparam int CA_SOFT_RESET_BIT = 0;
    localparam int CA_ENABLE = 1;
    localparam int CA_MODE_LO = 2;
    localparam int CA_PSYNC_LO = 4;
    localparam int CA_PRESC_LO = 8;
    localparam int CA_CAPTURE_CHANNEL_ENABLE_LO = 16;
    // control_b fields
    localparam int CB_DIR = 0;
    localparam int CB_SINGLE_SHOT = 2;
    // event control fields
    localparam int EV_ACT_LO = 0;
    localparam int EV_INV = 4;
    localparam int EV_EI = 5;
    // status fields
    localparam int ST_STOP = 0;
    localparam int ST_SYNCBUSY = 1;
    // counter mode encodings
    localparam logic [1:0] MODE_16 = 2'h0;
    localparam logic [1:0] MODE_8 = 2'h1;
    localparam logic [1:0] MODE_32 = 2'h2;
    // prescaler sync encodings
    localparam logic [1:0] PSYNC_CORE = 2'h0;
    localparam logic [1:0] PSYNC_PRESC = 2'h1;
    localparam logic [1:0] PSYNC_RESYNC = 2'h2;
    // event actions
    localparam logic [2:0] EVACT_OFF = 3'h0;
    localparam logic [2:0] EVACT_COUNT = 3'h1;
    localparam logic [2:0] EVACT_RETRIGGER = 3'h2;
    // waveform operations
    localparam logic [1:0] WAVE_NFRQ = 2'h0;
    localparam logic [1:0] WAVE_MFRQ = 2'h1;
    localparam logic [1:0] WAVE_NPWM = 2'h2;
    localparam logic [1:0] WAVE_MPWM = 2'h3;
    // reset values and timing
    localparam logic [31:0] CONTROL_A_RESET = 32'h0000_0000;
    localparam logic [31:0] PER_RESET = 32'hFFFF_FFFF;
    localparam int SYNC_CYCLES = 3;
    localparam int PRESC_MAX_DIV = 1024;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hw/tcsu_wsync.sv
`timescale 1ns/1ps
module tcsu_wsync #(
    parameter int LATENCY = tcsu_pkg::SYNC_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // handshake
    input wire logic start,
    output logic busy,
    output logic done
);
    import tcsu_pkg::*;

    initial begin
        if (LATENCY < 1 || LATENCY > 15) $error("tcsu_wsync: LATENCY out of range");
    end

    logic [3:0] cnt_r;

    // a new start restarts the delay so the latest value is what commits
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_r <= 4'h0;
            done <= 1'b0;
        end else if (start) begin
            cnt_r <= 4'(LATENCY);
            done <= 1'b0;
        end else begin
            done <= (cnt_r == 4'h1);
            if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end

    assign busy = (cnt_r != 4'h0) | start;
endmodule

// file: hw/tcsu_prescaler.sv
`timescale 1ns/1ps
module tcsu_prescaler #(
    parameter int MAX_DIV = tcsu_pkg::PRESC_MAX_DIV
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // control
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] select,
    // output
    output logic tick
);
    import tcsu_pkg::*;

    initial begin
        if (MAX_DIV != 1024) $error("tcsu_prescaler: only a 1024 ceiling is supported");
    end

    logic [9:0] cnt_r;
    logic [9:0] lastCount;

    always_comb begin
        case (select)
            3'h0: lastCount = 10'h000;
            3'h1: lastCount = 10'h001;
            3'h2: lastCount = 10'h003;
            3'h3: lastCount = 10'h007;
            3'h4: lastCount = 10'h00F;
            3'h5: lastCount = 10'h03F;
            3'h6: lastCount = 10'h0FF;
            default: lastCount = 10'h3FF;
        endcase
    end

    // count up to the selected value, then emit one tick and start over
    always_ff @(posedge core_clk) begin
        if (reset || restart || !run) begin
            cnt_r <= 10'h000;
        end else if (cnt_r >= lastCount) begin
            cnt_r <= 10'h000;
        end else begin
            cnt_r <= cnt_r + 10'h001;
        end
    end

    assign tick = run && !restart && (cnt_r >= lastCount);
endmodule

// file: hw/tcsu_core.sv
`timescale 1ns/1ps
// Function
// - protected fields accepted alongside enable set
// - widths 8, 16, 32; reset 16-bit
// - single_shot set via control_b_set
// - count_direction set counts down from period_limit
// - capture only on enabled channels
// - invert_enable inverts both output and pin input
// - enable bit starts and stops unit
// - soft reset clears all but debug
// - prescaler counts to value then ticks
// - update on core or prescaled pulse
// - division from 1 to 1/1024
// - event counting bypasses prescaler
// - counter advanced by event edges or prescaler ticks, not both
// - drive, wave, event writes synchronised
// - mode field two bits at 3:2
module tcsu_core #(
    parameter int CHANNELS = 2
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic eventIn,
    input wire logic [1:0] capturePin,
    input wire logic debugHalt,
    output logic [1:0] waveOut
);
    import tcsu_pkg::*;

    initial begin
        if (CHANNELS != 2) $error("tcsu_core: CHANNELS must be 2");
    end

    function automatic logic [31:0] applyStrobe(input logic [31:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[i*8 +: 8] = data[i*8 +: 8];
        end
        return res;
    endfunction

    function automatic logic [31:0] widthMax(input logic [1:0] mode);
        case (mode)
            MODE_8: widthMax = 32'h0000_00FF;
            MODE_32: widthMax = 32'hFFFF_FFFF;
            default: widthMax = 32'h0000_FFFF;
        endcase
    endfunction

    // bus slave state
    logic [7:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic doWrite;
    logic [31:0] wVal;

    // registers
    logic [31:0] control_a_r;
    logic [2:0] ctrlB_r;
    logic [5:0] event_control_reg_r, evctrlNew_r;
    logic [1:0] wave_r, waveNew_r;
    logic [1:0] drive_r, driveNew_r;
    logic debugRun_r;
    logic [31:0] count_r, per_r;
    logic [31:0] cc_r [2];
    logic stopped_r, updPend_r;

    logic softRst, rstAll;
    logic enable;
    logic [1:0] mode, psync;
    logic [2:0] presc, evAct;
    logic [1:0] capEn;
    logic evBusy, waveBusy, drvBusy, evDone, waveDone, drvDone;
    logic prescTick, countTick, updateNow, running;
    logic [31:0] top, maxVal;

    // pin synchronisers: stage one feeds only stage two
    logic evS1_r, evS2_r, evS3_r;
    logic [1:0] capS1_r, capS2_r, capS3_r;
    logic haltS1_r, haltS2_r;

    assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign softRst = doWrite && awAddr_r == OFF_CONTROL_A && wStrb_r[0] && wData_r[CA_SOFT_RESET_BIT];
    assign rstAll = reset || softRst;
    assign enable = control_a_r[CA_ENABLE];
    assign mode = control_a_r[CA_MODE_LO +: 2];
    assign psync = control_a_r[CA_PSYNC_LO +: 2];
    assign presc = control_a_r[CA_PRESC_LO +: 3];
    assign capEn = control_a_r[CA_CAPTURE_CHANNEL_ENABLE_LO +: 2];
    assign evAct = event_control_reg_r[EV_ACT_LO +: 3];
    assign maxVal = widthMax(mode);
    assign top = (wave_r == WAVE_MFRQ || wave_r == WAVE_MPWM) ? (cc_r[0] & maxVal)
                                                              : (per_r & maxVal);
    assign running = enable && !stopped_r && !(haltS2_r && !debugRun_r);

    // write address and data taken in either order, answered together
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr_r > OFF_CC1 || awAddr_r[1:0] != 2'h0 ||
                                awAddr_r == OFF_STATUS) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel; pending synchronised registers still show the old value
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                OFF_CONTROL_A: s_axi_rdata <= control_a_r;
                OFF_CTRLBCLR, OFF_CONTROL_B_SET: s_axi_rdata <= {29'h0, ctrlB_r};
                OFF_EVENT_CONTROL_REG: s_axi_rdata <= {26'h0, event_control_reg_r};
                OFF_WAVE: s_axi_rdata <= {30'h0, wave_r};
                OFF_DRIVE_CONTROL_REG: s_axi_rdata <= {30'h0, drive_r};
                OFF_DEBUG_CONTROL_REG: s_axi_rdata <= {31'h0, debugRun_r};
                OFF_STATUS: s_axi_rdata <= {30'h0, evBusy | waveBusy | drvBusy, stopped_r};
                OFF_COUNT: s_axi_rdata <= count_r;
                OFF_PER: s_axi_rdata <= per_r;
                OFF_CC0: s_axi_rdata <= cc_r[0];
                OFF_CC1: s_axi_rdata <= cc_r[1];
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    assign wVal = applyStrobe(32'h0000_0000, wData_r, wStrb_r);

    // control_a: protected fields only with enable set or while disabled
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            control_a_r <= CONTROL_A_RESET;
        end else if (doWrite && awAddr_r == OFF_CONTROL_A) begin
            if (!enable || (wStrb_r[0] && wData_r[CA_ENABLE])) begin
                control_a_r <= applyStrobe(control_a_r, wData_r, wStrb_r);
            end else if (wStrb_r[0]) begin
                control_a_r[CA_ENABLE] <= wData_r[CA_ENABLE];
            end
            control_a_r[CA_SOFT_RESET_BIT] <= 1'b0;
            control_a_r[31:18] <= 14'h0000;
            control_a_r[15:11] <= 5'h00;
            control_a_r[7:6] <= 2'h0;
        end
    end

    // control_b set and clear pair
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            ctrlB_r <= 3'h0;
        end else if (doWrite && awAddr_r == OFF_CONTROL_B_SET) begin
            ctrlB_r <= ctrlB_r | wVal[2:0];
        end else if (doWrite && awAddr_r == OFF_CTRLBCLR) begin
            ctrlB_r <= ctrlB_r & ~wVal[2:0];
        end
    end

    // debug control survives the soft reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            debugRun_r <= 1'b0;
        end else if (doWrite && awAddr_r == OFF_DEBUG_CONTROL_REG && wStrb_r[0]) begin
            debugRun_r <= wData_r[0];
        end
    end

    // staged registers: new value held until the crossing delay ends
    tcsu_wsync #(.LATENCY(SYNC_CYCLES)) evSync (
        .core_clk(core_clk),
        .reset(rstAll),
        .start(doWrite && awAddr_r == OFF_EVENT_CONTROL_REG),
        .busy(evBusy),
        .done(evDone)
    );
    tcsu_wsync #(.LATENCY(SYNC_CYCLES)) waveSync (
        .core_clk(core_clk),
        .reset(rstAll),
        .start(doWrite && awAddr_r == OFF_WAVE),
        .busy(waveBusy),
        .done(waveDone)
    );
    tcsu_wsync #(.LATENCY(SYNC_CYCLES)) drvSync (
        .core_clk(core_clk),
        .reset(rstAll),
        .start(doWrite && awAddr_r == OFF_DRIVE_CONTROL_REG),
        .busy(drvBusy),
        .done(drvDone)
    );

    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            evctrlNew_r <= 6'h00;
            waveNew_r <= 2'h0;
            driveNew_r <= 2'h0;
            event_control_reg_r <= 6'h00;
            wave_r <= WAVE_NFRQ;
            drive_r <= 2'h0;
        end else begin
            if (doWrite && awAddr_r == OFF_EVENT_CONTROL_REG) evctrlNew_r <= wVal[5:0];
            if (doWrite && awAddr_r == OFF_WAVE) waveNew_r <= wVal[1:0];
            if (doWrite && awAddr_r == OFF_DRIVE_CONTROL_REG) driveNew_r <= wVal[1:0];
            if (evDone) event_control_reg_r <= evctrlNew_r;
            if (waveDone) wave_r <= waveNew_r;
            if (drvDone) drive_r <= driveNew_r;
        end
    end

    // pin synchronisers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            evS1_r <= 1'b0;
            evS2_r <= 1'b0;
            evS3_r <= 1'b0;
            capS1_r <= 2'h0;
            capS2_r <= 2'h0;
            capS3_r <= 2'h0;
            haltS1_r <= 1'b0;
            haltS2_r <= 1'b0;
        end else begin
            evS1_r <= eventIn;
            evS2_r <= evS1_r;
            evS3_r <= evS2_r;
            capS1_r <= capturePin ^ drive_r;
            capS2_r <= capS1_r;
            capS3_r <= capS2_r;
            haltS1_r <= debugHalt;
            haltS2_r <= haltS1_r;
        end
    end

    logic evEdge;
    assign evEdge = event_control_reg_r[EV_EI] &&
                    ((evS2_r ^ event_control_reg_r[EV_INV]) && !(evS3_r ^ event_control_reg_r[EV_INV]));

    tcsu_prescaler #(.MAX_DIV(PRESC_MAX_DIV)) prescaler (
        .core_clk(core_clk),
        .reset(rstAll),
        .run(running),
        .restart(updateNow && psync == PSYNC_RESYNC),
        .select(presc),
        .tick(prescTick)
    );

    // events replace the prescaler when they are what is counted
    assign countTick = running &&
                       ((evAct == EVACT_COUNT) ? evEdge : prescTick);
    // wrap on the next core edge, or wait for the next prescaled pulse
    assign updateNow = updPend_r && enable &&
                       (psync != PSYNC_PRESC || presc == 3'h0 || prescTick);

    // counter
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            count_r <= 32'h0000_0000;
            updPend_r <= 1'b0;
            stopped_r <= 1'b0;
        end else if (doWrite && awAddr_r == OFF_CONTROL_B_SET && wVal[CB_DIR]) begin
            count_r <= top;
            updPend_r <= 1'b0;
            stopped_r <= 1'b0;
        end else if (doWrite && awAddr_r == OFF_COUNT) begin
            count_r <= applyStrobe(count_r, wData_r, wStrb_r) & maxVal;
        end else if (!enable) begin
            updPend_r <= 1'b0;
            stopped_r <= 1'b0;
        end else if (evAct == EVACT_RETRIGGER && evEdge) begin
            count_r <= ctrlB_r[CB_DIR] ? top : 32'h0000_0000;
            updPend_r <= 1'b0;
            stopped_r <= 1'b0;
        end else if (updateNow) begin
            updPend_r <= 1'b0;
            count_r <= ctrlB_r[CB_DIR] ? top : 32'h0000_0000;
            stopped_r <= ctrlB_r[CB_SINGLE_SHOT];
        end else if (countTick && !updPend_r) begin
            if (ctrlB_r[CB_DIR] ? (count_r == 32'h0000_0000) : (count_r >= top)) begin
                updPend_r <= 1'b1;
            end else if (ctrlB_r[CB_DIR]) begin
                count_r <= count_r - 32'h0000_0001;
            end else begin
                count_r <= (count_r + 32'h0000_0001) & maxVal;
            end
        end
    end

    // period register
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            per_r <= PER_RESET;
        end else if (doWrite && awAddr_r == OFF_PER) begin
            per_r <= applyStrobe(per_r, wData_r, wStrb_r);
        end
    end

    // compare and capture registers
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            cc_r[0] <= 32'h0000_0000;
            cc_r[1] <= 32'h0000_0000;
        end else begin
            for (int n = 0; n < 2; n++) begin
                if (enable && capEn[n] && capS2_r[n] && !capS3_r[n]) begin
                    cc_r[n] <= count_r;
                end else if (doWrite && awAddr_r == (OFF_CC0 + 8'(4 * n))) begin
                    cc_r[n] <= applyStrobe(cc_r[n], wData_r, wStrb_r);
                end
            end
        end
    end

    // waveform outputs
    logic [1:0] waveRaw_r;
    always_ff @(posedge core_clk) begin
        if (rstAll) begin
            waveRaw_r <= 2'h0;
        end else if (!enable) begin
            waveRaw_r <= 2'h0;
        end else begin
            case (wave_r)
                WAVE_NFRQ, WAVE_MFRQ: begin
                    if (updateNow) waveRaw_r[0] <= !waveRaw_r[0];
                    waveRaw_r[1] <= 1'b0;
                end
                WAVE_NPWM: begin
                    waveRaw_r[0] <= !capEn[0] && (count_r < (cc_r[0] & maxVal));
                    waveRaw_r[1] <= !capEn[1] && (count_r < (cc_r[1] & maxVal));
                end
                WAVE_MPWM: begin
                    waveRaw_r[0] <= 1'b0;
                    waveRaw_r[1] <= !capEn[1] && (count_r < (cc_r[1] & maxVal));
                end
                default: waveRaw_r <= 2'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            waveOut <= 2'h0;
        end else begin
            waveOut <= waveRaw_r ^ drive_r;
        end
    end
endmodule

// file: bench/tcsu_core_asserts.sv
`timescale 1ns/1ps
module tcsu_core_asserts
import tcsu_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_wtake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rtake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wans;
        s_wtake |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
    endproperty
    a_wans: assert property (p_wans) else $error("write answer missing");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_bdone;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    a_bdone: assert property (p_bdone) else $error("write channel not freed");
    property p_werr;
        s_wtake ##0 (s_axi_awaddr == OFF_STATUS) |=> ##1 s_axi_bresp == RESP_SLVERR;
    endproperty
    a_werr: assert property (p_werr) else $error("read-only write not refused");
    property p_rans;
        s_rtake |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rans: assert property (p_rans) else $error("read answer missing");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_rerr;
        s_rtake ##0 (s_axi_araddr > OFF_CC1) |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_rerr: assert property (p_rerr) else $error("unmapped read not refused");
    property p_idle;
        $fell(reset) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_idle: assert property (p_idle) else $error("bus not idle after reset");
endmodule

bind tcsu_core tcsu_core_asserts u_chk (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

// file: bench/tcsu_core_bench.sv
`timescale 1ns/1ps
module tcsu_core_bench;
import tcsu_pkg::*;
logic core_clk = 1'h0, reset = 1'h1, eventIn = 1'h0;
logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv, v;
logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp, waveOut, rsp, capturePin = 2'h0;
logic [31:0] mdl [int];
int fails = 0, comparisons = 0;
int dv [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
logic [7:0] so [3] = '{OFF_EVENT_CONTROL_REG, OFF_WAVE, OFF_DRIVE_CONTROL_REG};
logic [31:0] top [3] = '{32'hFF, 32'hFFFF, 32'hFFFF_FFFF};
logic [1:0] md [3] = '{MODE_8, MODE_16, MODE_32};

initial begin
    forever #5 core_clk = ~core_clk;
end

tcsu_core DUT (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .eventIn, .capturePin, .debugHalt(1'h0), .waveOut);

task automatic report_and_stop;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask

task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
        fails++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
endtask

task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
endtask

task automatic tmo(input int n);
    if (n >= 60) begin
        fails++;
        report_and_stop;
    end
endtask

task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 60 && !s_axi_bvalid; n++) begin
        @(posedge core_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    tmo(n);
endtask

task automatic rd(input logic [7:0] a);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 60 && !s_axi_rvalid; n++) begin
        @(posedge core_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    tmo(n);
endtask

task automatic rchk(input logic [7:0] a);
    rd(a);
    chk(rdv, mdl[a]);
endtask

// every readable register except the live status word
task automatic chk_all;
    for (int a = 0; a <= 8'h2C; a += 4) if (a != OFF_STATUS) rchk(a[7:0]);
endtask

task automatic sreset;
    wr(OFF_CONTROL_A, 32'h0);
    wr(OFF_CONTROL_A, 32'h1);
    for (int a = 0; a <= 8'h2C; a += 4) if (a != OFF_DEBUG_CONTROL_REG) mdl[a] = 32'h0;
    mdl[OFF_PER] = PER_RESET;
endtask

initial begin
    void'($urandom(93082));
    mdl[OFF_DEBUG_CONTROL_REG] = 32'h0;
    repeat (16) @(posedge core_clk);
    reset <= 1'h0;
    sreset;
    chk_all;
    foreach (so[i]) begin
        v = $urandom & ((i == 0) ? 32'h37 : 32'h3);
        wr(so[i], v);
        rchk(so[i]);
        mdl[so[i]] = v;
        repeat (6) @(posedge core_clk);
        rchk(so[i]);
    end
    chk({30'h0, waveOut}, v);
    wr(OFF_DEBUG_CONTROL_REG, 32'h1);
    mdl[OFF_DEBUG_CONTROL_REG] = 32'h1;
    wr(OFF_PER, 32'h1234);
    sreset;
    chk_all;
    foreach (md[i]) begin
        sreset;
        wr(OFF_CONTROL_A, {28'h0, md[i], 2'h0});
        wr(OFF_CONTROL_B_SET, 32'h5);
        rd(OFF_COUNT);
        chk(rdv, top[i]);
        wr(OFF_CTRLBCLR, 32'h4);
        mdl[OFF_CTRLBCLR] = 32'h1;
        rchk(OFF_CTRLBCLR);
    end
    sreset;
    wr(OFF_CONTROL_A, 32'h0706);
    mdl[OFF_CONTROL_A] = 32'h0706;
    rchk(OFF_CONTROL_A);
    wr(OFF_CONTROL_A, 32'h000A);
    mdl[OFF_CONTROL_A] = 32'h000A;
    rchk(OFF_CONTROL_A);
    wr(OFF_CONTROL_A, 32'h0000);
    mdl[OFF_CONTROL_A] = 32'h0008;
    rchk(OFF_CONTROL_A);
    // slack of a few ticks covers bus latency and prescaler phase
    for (int s = 0; s < 8; s++) begin
        sreset;
        wr(OFF_CONTROL_A, 32'h2 | (s << 8) | ((s % 3) << 4));
        repeat (2000) @(posedge core_clk);
        wr(OFF_CONTROL_A, 32'h0);
        rd(OFF_COUNT);
        v = 2004 / dv[s];
        chk(rdv + 4 >= v && rdv <= v + 4, 1);
    end
    sreset;
    wr(OFF_EVENT_CONTROL_REG, 32'h21);
    repeat (6) @(posedge core_clk);
    wr(OFF_CONTROL_A, 32'h0702);
    repeat (5) begin
        eventIn <= 1'h1;
        repeat (3) @(posedge core_clk);
        eventIn <= 1'h0;
        repeat (3) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    wr(OFF_CONTROL_A, 32'h0);
    rd(OFF_COUNT);
    chk(rdv, 32'h5);
    sreset;
    wr(OFF_CONTROL_A, 32'h0001_0002);
    repeat (20) @(posedge core_clk);
    capturePin <= 2'h3;
    repeat (5) @(posedge core_clk);
    capturePin <= 2'h0;
    repeat (5) @(posedge core_clk);
    wr(OFF_CONTROL_A, 32'h0);
    rd(OFF_CC0);
    chk(rdv != 32'h0, 1);
    rd(OFF_CC1);
    chk(rdv, 32'h0);
    wr(OFF_STATUS, 32'h1);
    chk_resp(rsp, RESP_SLVERR);
    rd(8'h30);
    chk_resp(rsp, RESP_SLVERR);
    report_and_stop;
end
endmodule
